// [src/ext_bus_map.vh]
// Register offsets, field positions and phase codes of the external bus unit
`ifndef EXT_BUS_MAP_VH
`define EXT_BUS_MAP_VH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_ADDR 8'h04
`define OFS_WDATA 8'h08
`define OFS_RDATA 8'h0C
`define OFS_STATUS 8'h10
`define OFS_CLKCFG 8'h14
`define OFS_TIMING_BLK 4'h2
// ----------------------------------------------------------------------
// Control, status and clock configuration register fields
// ----------------------------------------------------------------------
`define CTRL_START 0
`define CTRL_WRITE 1
`define CTRL_BHE 2
`define CTRL_WIN_LO 4
`define CTRL_WIN_HI 5
`define CTRL_MUX 8
`define STAT_BUSY 0
`define STAT_DONE 1
`define CLK_SRC_SYS 0
`define CLK_FAST_DRV 1
// ----------------------------------------------------------------------
// Timing register fields
// ----------------------------------------------------------------------
`define TIM_AB 0
`define TIM_C_LO 1
`define TIM_C_HI 2
`define TIM_D 3
`define TIM_E_LO 4
`define TIM_E_HI 8
`define TIM_F_LO 9
`define TIM_F_HI 10
`define TIM_RDY_EN 11
`define TIM_EXT_LO 12
`define TIM_EXT_HI 13
`define TIM_WIDTH 14
// ----------------------------------------------------------------------
// Phase codes and widths
// ----------------------------------------------------------------------
`define PH_IDLE 3'h0
`define PH_AB 3'h1
`define PH_C 3'h2
`define PH_D 3'h3
`define PH_E 3'h4
`define PH_F 3'h5
`define CNT_W 5
`define WIN_N 4
`define ADDR_W 24
`define DATA_W 16
`define RST_CTRL 9'h000
`endif

// [src/ext_bus_step_counter.v]
// Down counter of timing steps within one bus cycle phase
`timescale 1ns/1ps
`default_nettype none
module ext_bus_step_counter #(
  parameter W = 5
) (
  input wire clk_in,
  input wire rst_b_in,
  input wire load_in,
  input wire [W-1:0] load_val_in,
  output wire zero_out
);
  reg [W-1:0] count_r;
  assign zero_out = (count_r == {W{1'b0}});
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      count_r <= {W{1'b0}};
    end else if (load_in) begin
      count_r <= load_val_in;
    end else if (!zero_out) begin
      count_r <= count_r - {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

// [src/ext_bus_ref_clock.v]
// Reference clock output gate at the system clock rate
`timescale 1ns/1ps
`default_nettype none
module ext_bus_ref_clock (
  input wire clk_in,
  input wire rst_b_in,
  input wire src_sys_in,
  input wire fast_drv_in,
  output wire clk_out
);
  reg en_r;
  // Enable changes only while clock is low, so the gated clock never glitches
  reg en_low_r;
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      en_r <= 1'b0;
    end else begin
      en_r <= src_sys_in & fast_drv_in;
    end
  end
  always @(negedge clk_in) begin
    en_low_r <= en_r & rst_b_in;
  end
  // Period equals one system clock; a toggling flop would halve the rate
  assign clk_out = clk_in & en_low_r;
endmodule
`default_nettype wire

// [src/ext_bus_sequencer.v]
// External bus cycle sequencer with APB register access
// Operation
// - Each access runs address setup, command delay, data setup, access, hold in that order, command delay 0 to 3 steps.
// - Phase lengths come from the timing register of the chip-select window being accessed.
// - Address setup lasts 1 or 2 steps, plus up to 3 more when the window changed.
// - Data setup lasts 0 or 1 step; write data settles and shared lines float in multiplexed mode.
// - Access lasts 1 to 32 steps and may be stretched by the ready input when enabled.
// - A hold phase of 0 to 3 steps keeps address and write data driven.
// - Read data is captured on the edge that ends the read strobe.
// - Address changes after the read strobe ends do not disturb captured data.
// - Multiplexed 16-bit shared bus and demultiplexed 24-bit address plus 16-bit data modes exist.
// - A reference clock at the system clock period is driven when selected and enabled.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_map.vh"
module ext_bus_sequencer (
  input wire SYS_CLK_IN,
  input wire RST_B_IN,
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire [7:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  output reg [31:0] PRDATA_OUT,
  output reg PREADY_OUT,
  output reg PSLVERR_OUT,
  output reg [`WIN_N-1:0] CS_N_OUT,
  output reg ALE_OUT,
  output reg RD_N_OUT,
  output reg WR_N_OUT,
  output reg BYTE_HIGH_ENABLE_N_OUT,
  output reg [`ADDR_W-1:0] SEP_ADDR_OUT,
  output reg [`DATA_W-1:0] SEP_DATA_OUT,
  output reg SEP_DATA_OE_OUT,
  input wire [`DATA_W-1:0] SEP_DATA_IN,
  output reg [`DATA_W-1:0] SHARED_AD_OUT,
  output reg SHARED_AD_OE_OUT,
  input wire [`DATA_W-1:0] SHARED_AD_IN,
  input wire READY_IN,
  output wire REF_CLOCK_OUT
);
  // --------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------
  reg [8:0] ctrl_r;
  reg [`ADDR_W-1:0] addr_r;
  reg [`DATA_W-1:0] wdata_r;
  reg [`DATA_W-1:0] rdata_r;
  reg done_r;
  reg [1:0] clkcfg_r;
  reg [`TIM_WIDTH-1:0] timing_r [0:`WIN_N-1];
  reg start_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  wire apb_setup = PSEL_IN & ~PENABLE_IN;
  wire apb_commit = PSEL_IN & PENABLE_IN & PREADY_OUT;
  wire apb_wr = apb_commit & PWRITE_IN;
  // Four timing words, one per window, indexed by address bits 3:2
  wire is_timing = (PADDR_IN[7:4] == `OFS_TIMING_BLK) &
    (PADDR_IN[1:0] == 2'h0);
  wire [1:0] tim_idx = PADDR_IN[3:2];
  wire busy = (state_r != `PH_IDLE) | start_r;
  wire cycle_end;
  integer i;
  reg [31:0] rd_mux;
  reg map_hit;
  always @* begin
    rd_mux = 32'h0000_0000;
    map_hit = 1'b1;
    if (is_timing) begin
      rd_mux[`TIM_WIDTH-1:0] = timing_r[tim_idx];
    end else begin
      case (PADDR_IN)
        `OFS_CTRL: rd_mux[8:0] = ctrl_r;
        `OFS_ADDR: rd_mux[`ADDR_W-1:0] = addr_r;
        `OFS_WDATA: rd_mux[`DATA_W-1:0] = wdata_r;
        `OFS_RDATA: rd_mux[`DATA_W-1:0] = rdata_r;
        `OFS_STATUS: rd_mux[1:0] = {done_r, busy};
        `OFS_CLKCFG: rd_mux[1:0] = clkcfg_r;
        default: map_hit = 1'b0;
      endcase
    end
  end
  // One wait cycle per transfer: answers stay registered
  always @(posedge SYS_CLK_IN) begin
    if (!RST_B_IN) begin
      PREADY_OUT <= 1'b0;
      PRDATA_OUT <= 32'h0000_0000;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT <= PSEL_IN & PENABLE_IN & ~PREADY_OUT;
      if (PSEL_IN & PENABLE_IN & ~PREADY_OUT) begin
        PRDATA_OUT <= PWRITE_IN ? 32'h0000_0000 : rd_mux;
        PSLVERR_OUT <= ~map_hit;
      end else begin
        PRDATA_OUT <= 32'h0000_0000;
        PSLVERR_OUT <= 1'b0;
      end
    end
  end
  always @(posedge SYS_CLK_IN) begin
    if (!RST_B_IN) begin
      ctrl_r <= `RST_CTRL;
      addr_r <= {`ADDR_W{1'b0}};
      wdata_r <= {`DATA_W{1'b0}};
      clkcfg_r <= 2'h0;
      start_r <= 1'b0;
      for (i = 0; i < `WIN_N; i = i + 1) begin
        timing_r[i] <= {`TIM_WIDTH{1'b0}};
      end
    end else begin
      if (state_r == `PH_IDLE) begin
        start_r <= 1'b0;
      end
      // Settings are frozen while a cycle runs; a start while busy is lost
      if (apb_wr && !busy) begin
        if (is_timing) begin
          timing_r[tim_idx] <= PWDATA_IN[`TIM_WIDTH-1:0];
        end else begin
          case (PADDR_IN)
            `OFS_CTRL: begin
              ctrl_r <= {PWDATA_IN[8:1], 1'b0};
              start_r <= PWDATA_IN[`CTRL_START];
            end
            `OFS_ADDR: addr_r <= PWDATA_IN[`ADDR_W-1:0];
            `OFS_WDATA: wdata_r <= PWDATA_IN[`DATA_W-1:0];
            `OFS_CLKCFG: clkcfg_r <= PWDATA_IN[1:0];
            default: ;
          endcase
        end
      end
    end
  end
  // Done is sticky; a new completion wins over a write-one clear
  always @(posedge SYS_CLK_IN) begin
    if (!RST_B_IN) begin
      done_r <= 1'b0;
    end else if (cycle_end) begin
      done_r <= 1'b1;
    end else if (apb_wr && PADDR_IN == `OFS_STATUS &&
                 PWDATA_IN[`STAT_DONE]) begin
      done_r <= 1'b0;
    end
  end
  // --------------------------------------------------------------------
  // Phase lengths
  // --------------------------------------------------------------------
  wire [1:0] win = ctrl_r[`CTRL_WIN_HI:`CTRL_WIN_LO];
  wire [`TIM_WIDTH-1:0] sel_cfg = timing_r[win];
  reg [`TIM_WIDTH-1:0] cfg_r;
  reg [1:0] prev_win_r;
  reg prev_valid_r;
  wire win_changed = ~prev_valid_r | (prev_win_r != win);
  wire mux = ctrl_r[`CTRL_MUX];
  wire is_wr = ctrl_r[`CTRL_WRITE];
  // Address setup: base 1..2 steps, plus 0..3 on window change
  wire [`CNT_W-1:0] ab_last = {{(`CNT_W-1){1'b0}}, sel_cfg[`TIM_AB]} +
    (win_changed ? {{(`CNT_W-2){1'b0}},
    sel_cfg[`TIM_EXT_HI:`TIM_EXT_LO]} : {`CNT_W{1'b0}});
  wire [1:0] c_len = cfg_r[`TIM_C_HI:`TIM_C_LO];
  wire d_len = cfg_r[`TIM_D];
  wire [`CNT_W-1:0] e_last = cfg_r[`TIM_E_HI:`TIM_E_LO];
  wire [1:0] f_len = cfg_r[`TIM_F_HI:`TIM_F_LO];
  wire rdy_en = cfg_r[`TIM_RDY_EN];
  wire step_zero;
  reg cnt_load;
  reg [`CNT_W-1:0] cnt_val;
  ext_bus_step_counter #(
    .W(`CNT_W)
  ) u_step (
    .clk_in(SYS_CLK_IN),
    .rst_b_in(RST_B_IN),
    .load_in(cnt_load),
    .load_val_in(cnt_val),
    .zero_out(step_zero)
  );
  // --------------------------------------------------------------------
  // Phase sequencer
  // --------------------------------------------------------------------
  // Zero-length phases are skipped, never reordered
  always @* begin
    state_nxt = state_r;
    cnt_load = 1'b0;
    cnt_val = {`CNT_W{1'b0}};
    case (state_r)
      `PH_IDLE: begin
        if (start_r) begin
          state_nxt = `PH_AB;
          cnt_load = 1'b1;
          cnt_val = ab_last;
        end
      end
      `PH_AB, `PH_C: begin
        if (step_zero) begin
          cnt_load = 1'b1;
          if (state_r == `PH_AB && c_len != 2'h0) begin
            state_nxt = `PH_C;
            cnt_val = {{(`CNT_W-2){1'b0}}, c_len - 2'h1};
          end else if (d_len) begin
            state_nxt = `PH_D;
          end else begin
            state_nxt = `PH_E;
            cnt_val = e_last;
          end
        end
      end
      `PH_D: begin
        if (step_zero) begin
          state_nxt = `PH_E;
          cnt_load = 1'b1;
          cnt_val = e_last;
        end
      end
      `PH_E: begin
        // Ready sampled once per step only after the programmed steps
        if (step_zero && (!rdy_en || READY_IN)) begin
          if (f_len != 2'h0) begin
            state_nxt = `PH_F;
            cnt_load = 1'b1;
            cnt_val = {{(`CNT_W-2){1'b0}}, f_len - 2'h1};
          end else begin
            state_nxt = `PH_IDLE;
          end
        end
      end
      `PH_F: begin
        if (step_zero) begin
          state_nxt = `PH_IDLE;
        end
      end
      default: state_nxt = `PH_IDLE;
    endcase
  end
  assign cycle_end = (state_r != `PH_IDLE) && (state_nxt == `PH_IDLE);
  wire read_done = (state_r == `PH_E) && (state_nxt != `PH_E) && !is_wr;
  always @(posedge SYS_CLK_IN) begin
    if (!RST_B_IN) begin
      state_r <= `PH_IDLE;
      cfg_r <= {`TIM_WIDTH{1'b0}};
      prev_win_r <= 2'h0;
      prev_valid_r <= 1'b0;
      rdata_r <= {`DATA_W{1'b0}};
    end else begin
      state_r <= state_nxt;
      if (state_r == `PH_IDLE && start_r) begin
        cfg_r <= sel_cfg;
        prev_win_r <= win;
        prev_valid_r <= 1'b1;
      end
      // Same edge that raises the read strobe; the bus address is not
      // looked at here, so its change cannot disturb the data
      if (read_done) begin
        rdata_r <= mux ? SHARED_AD_IN : SEP_DATA_IN;
      end
    end
  end
  // --------------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------------
  wire act_nxt = (state_nxt != `PH_IDLE);
  wire ab_nxt = (state_nxt == `PH_AB);
  wire e_nxt = (state_nxt == `PH_E);
  wire wdat_nxt = (state_nxt == `PH_D) | e_nxt | (state_nxt == `PH_F);
  wire launch = (state_r == `PH_IDLE) && start_r;
  reg [`WIN_N-1:0] cs_dec;
  always @* begin
    cs_dec = {`WIN_N{1'b1}};
    if (act_nxt) begin
      cs_dec[win] = 1'b0;
    end
  end
  always @(posedge SYS_CLK_IN) begin
    if (!RST_B_IN) begin
      CS_N_OUT <= {`WIN_N{1'b1}};
      ALE_OUT <= 1'b0;
      RD_N_OUT <= 1'b1;
      WR_N_OUT <= 1'b1;
      BYTE_HIGH_ENABLE_N_OUT <= 1'b1;
      SEP_ADDR_OUT <= {`ADDR_W{1'b0}};
      SEP_DATA_OUT <= {`DATA_W{1'b0}};
      SEP_DATA_OE_OUT <= 1'b0;
      SHARED_AD_OUT <= {`DATA_W{1'b0}};
      SHARED_AD_OE_OUT <= 1'b0;
    end else begin
      CS_N_OUT <= cs_dec;
      ALE_OUT <= ab_nxt & mux;
      RD_N_OUT <= ~(e_nxt & ~is_wr);
      WR_N_OUT <= ~(e_nxt & is_wr);
      BYTE_HIGH_ENABLE_N_OUT <= ~(act_nxt & ctrl_r[`CTRL_BHE]);
      // Address held through hold phase; it changes only at a launch
      if (launch) begin
        SEP_ADDR_OUT <= addr_r;
      end
      SEP_DATA_OUT <= wdata_r;
      SEP_DATA_OE_OUT <= ~mux & is_wr & wdat_nxt;
      SHARED_AD_OUT <= ab_nxt ? addr_r[`DATA_W-1:0] : wdata_r;
      // Shared lines float in data setup and for the read access
      SHARED_AD_OE_OUT <= mux & (ab_nxt |
        (is_wr & (e_nxt | (state_nxt == `PH_F))));
    end
  end
  // --------------------------------------------------------------------
  // Reference clock
  // --------------------------------------------------------------------
  ext_bus_ref_clock u_refclk (
    .clk_in(SYS_CLK_IN),
    .rst_b_in(RST_B_IN),
    .src_sys_in(clkcfg_r[`CLK_SRC_SYS]),
    .fast_drv_in(clkcfg_r[`CLK_FAST_DRV]),
    .clk_out(REF_CLOCK_OUT)
  );
  // Edge spacing (12.5 ns) is software's concern: at 40 MHz one step is
  // 25 ns, so every bus edge is already far enough apart.
endmodule
`default_nettype wire

// [tb/ext_bus_sequencer_asserts.sv]
// Pin-level checks of the external bus cycle sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_map.vh"
module ext_bus_sequencer_asserts (
  input wire logic SYS_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic [`WIN_N-1:0] CS_N_OUT,
  input wire logic ALE_OUT,
  input wire logic RD_N_OUT,
  input wire logic WR_N_OUT,
  input wire logic [`ADDR_W-1:0] SEP_ADDR_OUT,
  input wire logic SEP_DATA_OE_OUT,
  input wire logic SHARED_AD_OE_OUT
);
  // ----------------------------------------------------------------
  // Cycle sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  wire idle = &CS_N_OUT;
  wire drv = SEP_DATA_OE_OUT || SHARED_AD_OE_OUT;
  sequence s_start;
    $fell(idle);
  endsequence
  sequence s_strobe;
    !RD_N_OUT || !WR_N_OUT;
  endsequence
  // Setup, delay and turnaround add up to nine steps at most
  a_cycle_opens: assert property (s_start |-> RD_N_OUT && WR_N_OUT)
    else $error("strobe active at cycle start");
  a_strobe_soon: assert property (s_start |-> ##[1:9] s_strobe)
    else $error("access phase late");
  a_strobe_in_cs: assert property (s_strobe |-> !idle)
    else $error("strobe outside chip select");
  a_one_window: assert property ($onehot0(~CS_N_OUT))
    else $error("several chip selects low");
  a_addr_held: assert property (!idle && $past(!idle) |-> $stable(SEP_ADDR_OUT))
    else $error("address moved inside cycle");
  a_hold_drives: assert property ($rose(WR_N_OUT) && !idle |-> drv)
    else $error("write data dropped in hold");
  a_wr_drives: assert property ($fell(WR_N_OUT) |-> drv)
    else $error("write data not driven");
  a_read_floats: assert property (!RD_N_OUT |-> !drv)
    else $error("lines driven during read");
  a_ale_addr: assert property (ALE_OUT |-> SHARED_AD_OE_OUT && !idle && RD_N_OUT && WR_N_OUT)
    else $error("latch strobe outside setup");
  a_err_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
    else $error("error without ready");
endmodule
bind ext_bus_sequencer ext_bus_sequencer_asserts u_chk (.SYS_CLK_IN, .RST_B_IN,
  .PREADY_OUT, .PSLVERR_OUT, .CS_N_OUT, .ALE_OUT, .RD_N_OUT, .WR_N_OUT,
  .SEP_ADDR_OUT, .SEP_DATA_OE_OUT, .SHARED_AD_OE_OUT);
`default_nettype wire

// [tb/ext_bus_mem_model.sv]
// Behavioural memory on the far side of the parallel bus
`timescale 1ns/1ps
`default_nettype none
module ext_bus_mem_model (
  input wire logic clk_in,
  input wire logic mux_in,
  input wire logic [3:0] slow_in,
  input wire logic ale_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic [23:0] addr_in,
  input wire logic [15:0] sep_data_in,
  input wire logic [15:0] sh_ad_in,
  output logic [15:0] rd_data_out,
  output logic ready_out
);
  logic [15:0] mem [0:15];
  logic [15:0] last_r = 16'h0000;
  logic [15:0] lat_r = 16'h0000;
  logic [3:0] wait_r = 4'h0;
  wire [3:0] idx = mux_in ? lat_r[3:0] : addr_in[3:0];
  initial for (int i = 0; i < 16; i++) mem[i] = 16'hA500 + 16'(i);
  always @(posedge clk_in) begin
    if (ale_in) lat_r <= sh_ad_in;
    if (!rd_n_in) last_r <= mem[idx];
    if (!wr_n_in) mem[idx] <= mux_in ? sh_ad_in : sep_data_in;
    if (rd_n_in && wr_n_in) wait_r <= 4'h0;
    else if (wait_r != 4'hF) wait_r <= wait_r + 4'h1;
  end
  // Inverted once released, so a late capture cannot pass by luck
  assign rd_data_out = !rd_n_in ? mem[idx] : ~last_r;
  assign ready_out = wait_r >= slow_in;
endmodule
`default_nettype wire

// [tb/external_bus_cycle_sequencer_bench.sv]
// Self-checking bench of the external bus cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module external_bus_cycle_sequencer_bench;
  logic clk, rst_b, psel, pen, pwr, mux, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  logic [3:0] slow;
  int num_errors = 0, samples_checked = 0;
  int pre, str, post, ale_n, bhe_n, ref_edges;
  wire [31:0] prdata;
  wire pready, pslverr, ale, rd_n, wr_n, bhe_n_w, sep_oe, sh_oe, ready, refc;
  wire [3:0] cs_n;
  wire [23:0] addr;
  wire [15:0] sep_o, sh_o, mdata;
  wire [15:0] sh = sh_oe ? sh_o : mdata;
  wire [15:0] sep = sep_oe ? sep_o : mdata;
  ext_bus_sequencer u_dut (.SYS_CLK_IN(clk), .RST_B_IN(rst_b),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .CS_N_OUT(cs_n), .ALE_OUT(ale), .RD_N_OUT(rd_n),
    .WR_N_OUT(wr_n), .BYTE_HIGH_ENABLE_N_OUT(bhe_n_w), .SEP_ADDR_OUT(addr),
    .SEP_DATA_OUT(sep_o), .SEP_DATA_OE_OUT(sep_oe), .SEP_DATA_IN(sep),
    .SHARED_AD_OUT(sh_o), .SHARED_AD_OE_OUT(sh_oe), .SHARED_AD_IN(sh),
    .READY_IN(ready), .REF_CLOCK_OUT(refc));
  ext_bus_mem_model u_mem (.clk_in(clk), .mux_in(mux), .slow_in(slow),
    .ale_in(ale), .rd_n_in(rd_n), .wr_n_in(wr_n), .addr_in(addr),
    .sep_data_in(sep), .sh_ad_in(sh), .rd_data_out(mdata), .ready_out(ready));
  // ----------------------------------------------------------------
  // Clock and helpers
  // ----------------------------------------------------------------
  always #12.5 clk = ~clk;
  always @(posedge refc) ref_edges++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1;
    n = 0;
    do begin @(posedge clk); #1; n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) num_errors++;
    rd = prdata; err = pslverr;
    @(posedge clk);
    psel <= 0; pen <= 0;
  endtask
  // Counts pin cycles before, during and after the strobe
  task automatic run(input logic [31:0] ctrl);
    int n;
    pre = 0; str = 0; post = 0; ale_n = 0; bhe_n = 0; n = 0;
    apb(1, 8'h00, ctrl);
    while (&cs_n && n < 20) begin @(posedge clk); #1; n++; end
    while (!(&cs_n) && n < 200) begin
      if (!rd_n || !wr_n) str++; else if (str == 0) pre++; else post++;
      ale_n += ale; bhe_n += !bhe_n_w;
      @(posedge clk); #1; n++;
    end
    if (n >= 200) num_errors++;
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs;
    apb(0, 8'h00, 0); chk(rd, 0);
    apb(0, 8'h10, 0); chk(rd, 0);
    apb(1, 8'h04, 32'hFFFFFFFF); apb(0, 8'h04, 0); chk(rd, 32'h00FFFFFF);
    apb(0, 8'h3C, 0); chk(err, 1); chk(rd, 0);
    $display("test regs done");
  endtask
  task t_demux;
    apb(1, 8'h20, 32'h264F); apb(1, 8'h04, 3);
    run(32'h1);
    chk(pre, 8); chk(str, 5); chk(post, 3);
    apb(0, 8'h0C, 0); chk(rd, 32'hA503);
    apb(0, 8'h10, 0); chk(rd, 2);
    apb(1, 8'h10, 2); apb(0, 8'h10, 0); chk(rd, 0);
    $display("test demux read done");
  endtask
  task t_win;
    apb(1, 8'h24, 32'h3000); apb(1, 8'h04, 5); apb(1, 8'h08, 32'h1234);
    run(32'h13);
    chk(pre, 4); chk(str, 1); chk(post, 0);
    run(32'h11); chk(pre, 1);
    apb(0, 8'h0C, 0); chk(rd, 32'h1234);
    $display("test window change done");
  endtask
  task t_ready;
    slow <= 4'h5;
    apb(1, 8'h28, 32'h1F0); run(32'h21); chk(str, 32);
    slow <= 4'h4;
    apb(1, 8'h28, 32'h800); run(32'h21); chk(str >= 4 && str <= 8, 1);
    slow <= 4'h0;
    $display("test ready done");
  endtask
  task t_mux;
    mux <= 1;
    apb(1, 8'h2C, 0); apb(1, 8'h04, 7); apb(1, 8'h08, 32'hBEEF);
    run(32'h137); chk(ale_n, 1); chk(bhe_n, pre + str + post);
    run(32'h131); apb(0, 8'h0C, 0); chk(rd, 32'hBEEF);
    mux <= 0;
    $display("test mux done");
  endtask
  task t_clk;
    apb(1, 8'h14, 3); @(posedge clk); #1; ref_edges = 0;
    repeat (10) @(posedge clk);
    #1; chk(ref_edges, 10);
    apb(1, 8'h14, 1); @(posedge clk); #1; ref_edges = 0;
    repeat (10) @(posedge clk);
    #1; chk(ref_edges, 0);
    $display("test ref clock done");
  endtask
  initial begin
    clk = 0; rst_b = 0; psel = 0; pen = 0; pwr = 0; paddr = 0;
    pwdata = 0; mux = 0; slow = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1;
    t_regs; t_demux; t_win; t_ready; t_mux; t_clk;
    print_verdict;
  end
  initial begin
    #150000;
    num_errors++;
    print_verdict;
  end
endmodule
`default_nettype wire
